// [rtl/dbc_consts.vh]
`ifndef DBC_CONSTS_VH
`define DBC_CONSTS_VH
`define DBC_WIDTH 12
`define DBC_CLK_MHZ 40
`define DBC_MIN_LOW_NS 500
`define DBC_CLK_PERIOD_NS 25
`define DBC_MIN_LOW_CYC \
  ((`DBC_MIN_LOW_NS + `DBC_CLK_PERIOD_NS - 1) / `DBC_CLK_PERIOD_NS)
`define DBC_ZERO 12'h000
`endif

// [rtl/dbc_pulse_qual.v]
`include "dbc_consts.vh"
module dbc_pulse_qual #(
  parameter MIN_CYC = `DBC_MIN_LOW_CYC
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Pin
  input wire pin_b_i,
  // Qualified events
  output wire fall_o,
  output wire valid_o,
  output wire low_o
);
  reg s1_r;
  reg s2_r;
  reg prev_r;
  reg [15:0] cnt_r;
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= 1'h1;
      s2_r <= 1'h1;
      prev_r <= 1'h1;
      cnt_r <= 16'h0000;
    end else begin
      s1_r <= pin_b_i;
      s2_r <= s1_r;
      prev_r <= s2_r;
      if (s2_r)
        cnt_r <= 16'h0000;
      else if (cnt_r != MIN_CYC[15:0])
        cnt_r <= cnt_r + 16'h0001;
    end
  end
  assign low_o = ~s2_r;
  assign fall_o = prev_r & ~s2_r;
  // One pulse when the low has lasted the minimum time
  assign valid_o = ~s2_r & (cnt_r == MIN_CYC[15:0] - 16'h0001);
endmodule // dbc_pulse_qual

// [rtl/dbc_top.v]
`include "dbc_consts.vh"
module dbc_top #(
  parameter WIDTH = `DBC_WIDTH,
  parameter MIN_CYC = `DBC_MIN_LOW_CYC
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Control pulses, active low
  input wire count_b_i,
  input wire xfer_b_i,
  input wire clr_b_i,
  // Parallel data
  input wire [WIDTH-1:0] data_i,
  // Converter code and digital outputs
  output wire [WIDTH-1:0] dac_code_o,
  output wire [WIDTH-1:0] data_o
);
  // Clear tracking states, one-hot
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_CLEAR = 3'h2;
  localparam [2:0] ST_RELEASE = 3'h4;

  // Buffer update selects, one-hot, all zeros for none
  localparam [2:0] EV_NONE = 3'h0;
  localparam [2:0] EV_INC = 3'h1;
  localparam [2:0] EV_LOAD = 3'h2;
  localparam [2:0] EV_CLR = 3'h4;

  // Synchronised data pins
  reg [WIDTH-1:0] d1_r;
  reg [WIDTH-1:0] d2_r;
  wire [WIDTH-1:0] load_val;

  // Buffer and its next value
  reg [WIDTH-1:0] buf_r;
  reg [WIDTH-1:0] buf_nxt;

  // Clear tracking state
  reg [2:0] st_r;
  reg [2:0] st_nxt;

  // Selected buffer update for this cycle
  reg [2:0] ev_sel;

  // Qualified pin events
  wire cnt_fall;
  wire xf_fall;
  wire clr_low;
  wire ev_blocked;

  // Requests before priority
  wire req_clr;
  wire req_load;
  wire req_inc;

  // Incrementer
  wire [WIDTH-1:0] inc_val;
  wire [WIDTH-1:0] carry;
  genvar gi;

  // Count pin: each synchronised falling edge is one step
  dbc_pulse_qual #(
    .MIN_CYC(MIN_CYC)
  ) u_cnt (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .pin_b_i(count_b_i),
    .fall_o(cnt_fall),
    .valid_o(),
    .low_o()
  );

  // Transfer pin: each synchronised falling edge is one load
  dbc_pulse_qual #(
    .MIN_CYC(MIN_CYC)
  ) u_xf (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .pin_b_i(xfer_b_i),
    .fall_o(xf_fall),
    .valid_o(),
    .low_o()
  );

  // Clear pin: acts for as long as its synchronised level is low
  dbc_pulse_qual #(
    .MIN_CYC(MIN_CYC)
  ) u_clr (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .pin_b_i(clr_b_i),
    .fall_o(),
    .valid_o(),
    .low_o(clr_low)
  );

  // Data pins pass two flip-flops; the second stage is what a transfer
  // loads, so data must settle before the transfer pulse falls
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      d1_r <= `DBC_ZERO;
    end else begin
      d1_r <= data_i;
    end
  end

  // Second data stage, the only reader of the first
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      d2_r <= `DBC_ZERO;
    end else begin
      d2_r <= d1_r;
    end
  end

  assign load_val = d2_r;

  // Ripple incrementer; the carry out of the top bit is dropped, so
  // all ones steps to all zeros
  assign carry[0] = 1'h1;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_inc
      assign inc_val[gi] = buf_r[gi] ^ carry[gi];
      if (gi < WIDTH - 1) begin : g_carry
        assign carry[gi + 1] = buf_r[gi] & carry[gi];
      end
    end
  endgenerate

  // The two cycles after clear lets go (ST_CLEAR, then ST_RELEASE) still count as clear, so a pulse
  // that falls just as clear is released is ignored as well
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN: begin
        if (clr_low) begin
          st_nxt = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        if (!clr_low) begin
          st_nxt = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (clr_low) begin
          st_nxt = ST_CLEAR;
        end else begin
          st_nxt = ST_RUN;
        end
      end
      default: begin
        st_nxt = ST_RUN;
      end
    endcase
  end

  // Clear tracking register
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= ST_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ev_blocked = (st_r != ST_RUN);
  assign req_clr = clr_low;
  assign req_load = xf_fall & ~ev_blocked;
  assign req_inc = cnt_fall & ~ev_blocked;

  // Clear beats transfer, transfer beats count
  always @* begin
    ev_sel = EV_NONE;
    if (req_clr) begin
      ev_sel = EV_CLR;
    end else if (req_load) begin
      ev_sel = EV_LOAD;
    end else if (req_inc) begin
      ev_sel = EV_INC;
    end else begin
      ev_sel = EV_NONE;
    end
  end

  // Count and transfer act at the synchronised falling edge, clear while low; the minimum width is
  // the driver's duty and shorter pulses are not rejected
  always @* begin
    buf_nxt = buf_r;
    case (ev_sel)
      EV_CLR: begin
        buf_nxt = `DBC_ZERO;
      end
      EV_LOAD: begin
        buf_nxt = load_val;
      end
      EV_INC: begin
        buf_nxt = inc_val;
      end
      EV_NONE: begin
        buf_nxt = buf_r;
      end
      default: begin
        buf_nxt = buf_r;
      end
    endcase
  end

  // Buffer register
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_r <= `DBC_ZERO;
    end else begin
      buf_r <= buf_nxt;
    end
  end

  // Both outputs are the buffer flip-flops themselves
  assign dac_code_o = buf_r;
  assign data_o = buf_r;
endmodule // dbc_top

// [tb/dbc_properties.sv]
module dbc_properties #(parameter WIDTH = 12) (
  input wire ref_clk_i, rst_b_i, count_b_i, xfer_b_i, clr_b_i,
  input wire [WIDTH-1:0] data_i, dac_code_o, data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_outs_equal: assert property (dac_code_o == data_o)
    else $error("outputs differ");
  a_clear_zero: assert property (
    !clr_b_i [*5] |-> dac_code_o == 0) else $error("no clear");
  a_count_one: assert property (
    $fell(count_b_i) && xfer_b_i && clr_b_i
    |-> ##6 dac_code_o == $past(dac_code_o, 6) + 1'b1)
    else $error("bad count");
  a_xfer_load: assert property (
    $fell(xfer_b_i) && clr_b_i |-> ##6 dac_code_o == data_i)
    else $error("no load");
  a_count_wrap: assert property (
    $fell(count_b_i) && xfer_b_i && clr_b_i && dac_code_o == '1
    |-> ##6 dac_code_o == 0) else $error("no wrap");
  a_idle_stable: assert property (
    (count_b_i && xfer_b_i && clr_b_i) [*4] |-> $stable(dac_code_o))
    else $error("code moved while idle");
  cover property ($fell(count_b_i));
  cover property ($fell(xfer_b_i) && !clr_b_i);
  cover property (dac_code_o == '1 ##[1:40] dac_code_o == 0);
endmodule // dbc_properties
bind dbc_top dbc_properties #(.WIDTH(WIDTH)) u_props (.*);

// [tb/dbc_ctl_model.sv]
module dbc_ctl_model (
  input wire ref_clk_i,
  output logic count_b_o = 1'h1, xfer_b_o = 1'h1, clr_b_o = 1'h1
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic pulse(input logic [2:0] k);
    {clr_b_o, xfer_b_o, count_b_o} <= ~k;
    repeat (20) @(posedge ref_clk_i);
    {clr_b_o, xfer_b_o, count_b_o} <= 3'h7;
    repeat (8) @(posedge ref_clk_i);
  endtask
endmodule // dbc_ctl_model

// [tb/dbc_top_bench.sv]
module dbc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'h0, rst_b_i = 1'h0;
  logic [11:0] data_i = 12'h000, exp_v = 12'h000;
  wire count_b_i, xfer_b_i, clr_b_i;
  wire [11:0] dac_code_o, data_o;
  int miscompares = 0, n_checks = 0;
  dbc_top dut (.*);
  dbc_ctl_model u_m (.ref_clk_i(ref_clk_i), .count_b_o(count_b_i),
    .xfer_b_o(xfer_b_i), .clr_b_o(clr_b_i));
  function automatic logic [11:0] nxt(logic [2:0] k, logic [11:0] d, v);
    return k[2] ? 12'h000 : k[1] ? d : v + k[0];
  endfunction
  task automatic chk(input logic [11:0] seen, want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic step(input logic [2:0] k, input logic [11:0] d);
    data_i <= d;
    repeat (4) @(posedge ref_clk_i);
    exp_v = nxt(k, d, exp_v);
    u_m.pulse(k);
    chk(dac_code_o, exp_v);
    chk(data_o, exp_v);
  endtask
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  initial begin
    #100us;
    miscompares++;
    print_verdict;
  end
  initial begin
    void'($urandom(71));
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'h1;
    chk(dac_code_o, 12'h000);
    step(3'h2, 12'hfff);
    step(3'h1, 12'h5a5);
    step(3'h6, 12'h5a5);
    repeat (60) step(3'($urandom_range(7, 1)), 12'($urandom));
    print_verdict;
  end
endmodule // dbc_top_bench
